// ===== src/rbad_top.sv
// Rebuild-assist diagnostic page handler with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "rbad_cfg.svh"

module rbad_top #(
	parameter int          ELEM_BYTES  = 2,
	parameter int          LBA_W       = 32,
	parameter logic [31:0] SUPP_RST    = 32'hFFFF_FFFF,
	parameter logic [7:0]  MRE_ASC     = 8'h11,
	parameter logic [7:0]  MRE_ASCQ    = 8'h1D
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Avalon-MM slave
	input  wire logic [4:0]                    address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	output var  logic [31:0]                   readdata,
	output logic                               waitrequest,
	output logic                               irq,
	// Results request
	input  wire logic                          diag_req,
	input  wire logic [7:0]                    diag_page,
	output logic                               diag_req_ready,
	// Input page bytes to the initiator
	output var  logic                          pg_out_valid,
	output var  logic [7:0]                    pg_out_data,
	output var  logic                          pg_out_last,
	input  wire logic                          pg_out_ready,
	// Output page bytes from the initiator
	input  wire logic                          pg_in_valid,
	input  wire logic [7:0]                    pg_in_data,
	input  wire logic                          pg_in_last,
	output logic                               pg_in_ready,
	// Diagnostic command completion
	output var  logic                          cmd_done,
	output var  logic                          cmd_check,
	output var  logic [3:0]                    sense_key,
	output var  logic [7:0]                    sense_asc,
	output var  logic [7:0]                    sense_ascq,
	// Media access lookup
	input  wire logic                          acc_valid,
	input  wire logic                          acc_read,
	input  wire logic [LBA_W-1:0]              acc_lba,
	input  wire logic [$clog2(8*ELEM_BYTES)-1:0] acc_elem,
	output var  logic                          acc_done,
	output var  logic                          acc_predicted,
	// Read command framing and report
	input  wire logic                          read_start,
	input  wire logic                          read_end,
	output var  logic                          read_done,
	output var  logic                          read_check,
	output var  logic [3:0]                    read_key,
	output var  logic [7:0]                    read_asc,
	output var  logic [7:0]                    read_ascq,
	output var  logic [LBA_W-1:0]              read_info,
	output var  logic [LBA_W-1:0]              read_csi
);

	localparam int         EW        = 8 * ELEM_BYTES;
	localparam logic [15:0] PAGE_LEN = 16'(4 + 2 * ELEM_BYTES);
	localparam logic [5:0] LAST_IDX  = 6'(7 + 2 * ELEM_BYTES);
	localparam logic [5:0] TOTAL     = 6'(8 + 2 * ELEM_BYTES);
	localparam logic [5:0] DIS_IDX   = 6'(8 + ELEM_BYTES);
	localparam logic [7:0] ELEN      = 8'(ELEM_BYTES);

	// Mode state
	logic                mode;
	logic [EW-1:0]       supp;
	logic [EW-1:0]       dis;
	// Output page capture
	logic [5:0]          in_cnt;
	logic                eval;
	logic [7:0]          in_code;
	logic [15:0]         in_plen;
	logic                in_en;
	logic [7:0]          in_n;
	logic [EW-1:0]       in_dis;
	// Input page streaming
	rbad_pkg::rbad_out_state_type out_state;
	logic [5:0]          out_idx;
	// Bus and interrupts
	logic                ack;
	logic                acc_rd;
	logic                acc_wr;
	logic [`RBAD_IRQ_BITS-1:0] irq_stat;
	logic [`RBAD_IRQ_BITS-1:0] irq_mask;
	logic [`RBAD_IRQ_BITS-1:0] irq_ev;
	// Read run tracker
	logic                run_have;
	logic                run_open;
	logic [LBA_W-1:0]    run_first;
	logic [LBA_W-1:0]    run_last;

	// Byte of the input page at a given index, fields sent MSB first
	function automatic logic [7:0] page_byte(input logic [5:0] idx, input logic m,
			input logic [EW-1:0] s, input logic [EW-1:0] d);
		logic [7:0] b;
		int         k;
		b = 8'h00;
		k = 0;
		if (idx == `RBAD_BYTE_CODE) begin
			b = `RBAD_PAGE_CODE; // RQ1
		end else if (idx == `RBAD_BYTE_PLEN_HI) begin
			b = PAGE_LEN[15:8]; // RQ3
		end else if (idx == `RBAD_BYTE_PLEN_LO) begin
			b = PAGE_LEN[7:0]; // RQ3
		end else if (idx == `RBAD_BYTE_ENABLE) begin
			b = {7'h00, m}; // RQ2
		end else if (idx == `RBAD_BYTE_ELEN) begin
			b = ELEN; // RQ3
		end else if (idx >= `RBAD_BYTE_FIELDS && idx < DIS_IDX) begin
			k = ELEM_BYTES - 1 - (int'(idx) - 8);
			b = s[8*k +: 8]; // RQ4
		end else if (idx >= DIS_IDX && idx <= LAST_IDX) begin
			k = ELEM_BYTES - 1 - (int'(idx) - int'(DIS_IDX));
			b = d[8*k +: 8]; // RQ5
		end
		return b;
	endfunction

	// Handshakes: one command at a time, so reads never see a half-applied page
	assign pg_in_ready    = (out_state == rbad_pkg::RBAD_OUT_IDLE) && !eval;
	assign diag_req_ready = pg_in_ready && (in_cnt == 6'h00);

	// Validation of a captured output page
	logic bad_len;
	logic bad_page;
	logic bad_dis;
	assign bad_len  = (in_n != ELEN); // RQ10
	assign bad_page = (in_code != `RBAD_PAGE_CODE) || (in_plen != PAGE_LEN) || (in_cnt < TOTAL);
	assign bad_dis  = ((in_dis & ~supp) != '0)                      // RQ14
		|| ((supp != '0) && ((in_dis & supp) == supp))             // RQ14
		|| ((dis & ~in_dis) != '0);                                // RQ14

	logic reject;
	// A page cut before its enable byte is refused, never taken as a disable
	assign reject = in_en ? (bad_len || bad_page || bad_dis)
		: ((in_code != `RBAD_PAGE_CODE) || (in_cnt <= `RBAD_BYTE_ENABLE));

	// Capture of output page bytes; mask bytes are dropped on the floor
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_cnt  <= 6'h00;
			eval    <= 1'b0;
			in_code <= 8'h00;
			in_plen <= 16'h0000;
			in_en   <= 1'b0;
			in_n    <= 8'h00;
			in_dis  <= '0;
		end else if (eval) begin
			eval   <= 1'b0;
			in_cnt <= 6'h00;
			in_dis <= '0;
			in_n   <= 8'h00;
			in_en  <= 1'b0;
		end else if (pg_in_valid && pg_in_ready) begin
			if (in_cnt != 6'h3F) begin
				in_cnt <= in_cnt + 6'h01; // Saturates on oversized pages
			end
			eval <= pg_in_last;
			unique case (in_cnt)
				`RBAD_BYTE_CODE:    in_code <= pg_in_data;
				`RBAD_BYTE_PLEN_HI: in_plen[15:8] <= pg_in_data;
				`RBAD_BYTE_PLEN_LO: in_plen[7:0] <= pg_in_data;
				`RBAD_BYTE_ENABLE:  in_en <= pg_in_data[`RBAD_BIT_ENABLE];
				`RBAD_BYTE_ELEN:    in_n <= pg_in_data;
				default: begin
					if (in_cnt >= DIS_IDX && in_cnt <= LAST_IDX) begin
						in_dis[8*(ELEM_BYTES-1-(int'(in_cnt)-int'(DIS_IDX))) +: 8] <= pg_in_data;
					end
				end
			endcase // RQ11
		end
	end

	// Mode and disabled elements: change only after the whole page checks out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= 1'b0;
			dis  <= '0;
		end else if (eval && !reject) begin
			if (in_en) begin
				mode <= 1'b1;   // RQ7
				dis  <= in_dis; // RQ12 RQ13
			end else begin
				mode <= 1'b0; // RQ8
				dis  <= '0;   // RQ8
			end
		end
	end

	// Input page streaming, one byte per accepted beat
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_state    <= rbad_pkg::RBAD_OUT_IDLE;
			out_idx      <= 6'h00;
			pg_out_valid <= 1'b0;
			pg_out_data  <= 8'h00;
			pg_out_last  <= 1'b0;
		end else begin
			unique case (out_state)
				rbad_pkg::RBAD_OUT_IDLE: begin
					if (diag_req && diag_req_ready && diag_page == `RBAD_PAGE_CODE) begin
						out_state    <= rbad_pkg::RBAD_OUT_SEND; // RQ1
						out_idx      <= 6'h00;
						pg_out_valid <= 1'b1;
						pg_out_data  <= page_byte(6'h00, mode, supp, dis);
						pg_out_last  <= 1'b0;
					end
				end
				rbad_pkg::RBAD_OUT_SEND: begin
					if (pg_out_ready) begin
						if (pg_out_last) begin
							out_state    <= rbad_pkg::RBAD_OUT_IDLE;
							pg_out_valid <= 1'b0;
							pg_out_last  <= 1'b0;
						end else begin
							out_idx     <= out_idx + 6'h01;
							pg_out_data <= page_byte(out_idx + 6'h01, mode, supp, dis);
							pg_out_last <= (out_idx + 6'h01) == LAST_IDX; // RQ3
						end
					end
				end
			endcase
		end
	end

	// Diagnostic completion and sense data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_done   <= 1'b0;
			cmd_check  <= 1'b0;
			sense_key  <= `RBAD_SK_GOOD;
			sense_asc  <= `RBAD_ASC_NONE;
			sense_ascq <= `RBAD_ASCQ_ZERO;
		end else begin
			cmd_done <= 1'b0;
			if (eval) begin
				cmd_done   <= 1'b1;
				cmd_check  <= reject;
				sense_key  <= reject ? `RBAD_SK_ILLEGAL : `RBAD_SK_GOOD;      // RQ10 RQ14
				sense_asc  <= reject ? `RBAD_ASC_INV_PARAM : `RBAD_ASC_NONE;  // RQ10 RQ14
				sense_ascq <= `RBAD_ASCQ_ZERO;
			end else if (diag_req && diag_req_ready && diag_page != `RBAD_PAGE_CODE) begin
				cmd_done   <= 1'b1;
				cmd_check  <= 1'b1;
				sense_key  <= `RBAD_SK_ILLEGAL;
				sense_asc  <= `RBAD_ASC_INV_CDB;
				sense_ascq <= `RBAD_ASCQ_ZERO;
			end else if (out_state == rbad_pkg::RBAD_OUT_SEND && pg_out_ready && pg_out_last) begin
				cmd_done   <= 1'b1;
				cmd_check  <= 1'b0;
				sense_key  <= `RBAD_SK_GOOD;
				sense_asc  <= `RBAD_ASC_NONE;
				sense_ascq <= `RBAD_ASCQ_ZERO;
			end
		end
	end

	// Media lookup: an element counts only while the mode is on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_done      <= 1'b0;
			acc_predicted <= 1'b0;
		end else begin
			acc_done      <= acc_valid;
			acc_predicted <= acc_valid && mode && dis[acc_elem]; // RQ5 RQ12 RQ13
		end
	end

	// Read run tracker: first failing LBA and end of its contiguous run
	logic pred_rd;
	assign pred_rd = acc_valid && acc_read && mode && dis[acc_elem];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_have  <= 1'b0;
			run_open  <= 1'b0;
			run_first <= '0;
			run_last  <= '0;
		end else if (read_start) begin
			run_have <= 1'b0;
			run_open <= 1'b0;
		end else if (pred_rd) begin
			if (!run_have) begin
				run_have  <= 1'b1; // RQ15
				run_open  <= 1'b1;
				run_first <= acc_lba;
				run_last  <= acc_lba;
			end else if (run_open && acc_lba == run_last + LBA_W'(1)) begin
				run_last <= acc_lba; // RQ15
			end else begin
				run_open <= 1'b0; // A gap closes the run for good
			end
		end else if (acc_valid && acc_read && run_have) begin
			run_open <= 1'b0; // A clean block also ends contiguity
		end
	end

	// Read report at the end of each read command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			read_done  <= 1'b0;
			read_check <= 1'b0;
			read_key   <= `RBAD_SK_GOOD;
			read_asc   <= `RBAD_ASC_NONE;
			read_ascq  <= `RBAD_ASCQ_ZERO;
			read_info  <= '0;
			read_csi   <= '0;
		end else begin
			read_done <= read_end;
			if (read_end) begin
				read_check <= run_have;
				read_key   <= run_have ? `RBAD_SK_ABORTED : `RBAD_SK_GOOD; // RQ15
				read_asc   <= run_have ? MRE_ASC : `RBAD_ASC_NONE;         // RQ15
				read_ascq  <= run_have ? MRE_ASCQ : `RBAD_ASCQ_ZERO;       // RQ15
				read_info  <= run_first;
				read_csi   <= run_last;
			end
		end
	end

	// Avalon slave: one wait cycle, then the access completes
	assign waitrequest = (read || write) && !ack;
	assign acc_rd      = read && ack;
	assign acc_wr      = write && ack;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (read || write) && !ack;
		end
	end

	// Read data is latched in the wait cycle and stands at the accept edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack) begin
			unique case (address)
				`RBAD_REG_STATUS:   readdata <= 32'(mode);
				`RBAD_REG_SUPPORT:  readdata <= 32'(supp);
				`RBAD_REG_DISABLED: readdata <= 32'(dis);
				`RBAD_REG_IRQ_STAT: readdata <= 32'(irq_stat);
				`RBAD_REG_IRQ_MASK: readdata <= 32'(irq_mask);
				`RBAD_REG_SENSE:    readdata <= {12'h000, sense_key, sense_asc, sense_ascq};
				default:            readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Writable registers; the supported set steers validation and the input page
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			supp     <= SUPP_RST[EW-1:0];
			irq_mask <= `RBAD_IRQ_MASK_RST;
		end else if (acc_wr) begin
			if (address == `RBAD_REG_SUPPORT) begin
				supp <= writedata[EW-1:0]; // RQ4
			end
			if (address == `RBAD_REG_IRQ_MASK) begin
				irq_mask <= writedata[`RBAD_IRQ_BITS-1:0];
			end
		end
	end

	// Sticky events; a read clears only the bits it returned, so new events survive
	always_comb begin
		irq_ev = '0;
		irq_ev[`RBAD_IRQ_MODE_CHG]  = eval && !reject && (mode != in_en);
		irq_ev[`RBAD_IRQ_REJECT]    = eval && reject;
		irq_ev[`RBAD_IRQ_PRED_READ] = read_end && run_have;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat <= '0;
		end else if (acc_rd && address == `RBAD_REG_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~readdata[`RBAD_IRQ_BITS-1:0]) | irq_ev;
		end else begin
			irq_stat <= irq_stat | irq_ev;
		end
	end

	assign irq = (irq_stat & irq_mask) != '0;

endmodule
`default_nettype wire

// ===== src/rbad_cfg.svh
// Constants for the rebuild-assist diagnostic page block
// Functional notes
// RQ1: A results request for page 42h returns the rebuild-assist input page.
// RQ2: Input page byte 4 bit 0 shows one while rebuild assist mode is on.
// RQ3: Byte 7 holds n; mask and disable fields take n bytes each; length 4+2n.
// RQ4: Each mask bit is one exactly when that disable bit is supported.
// RQ5: Disabled elements read back as ones and give predicted read and write errors.
// RQ6: The initiator changes the mode only by sending the output page.
// RQ7: Enable set: validate every field first, then enter rebuild assist mode.
// RQ8: Enable clear: leave the mode, ignore other fields, re-enable all elements.
// RQ9: The initiator copies the reported element length into the output page.
// RQ10: A wrong element length ends with ILLEGAL REQUEST, invalid parameter field.
// RQ11: Mask bytes of a received output page are ignored.
// RQ12: A disable bit of one makes that element's LBAs act as predicted errors.
// RQ13: A disable bit of zero makes that element's LBAs free of predicted errors.
// RQ14: Reject unsupported bits, all supported bits set, or clearing set bits.
// RQ15: Predicted read errors give ABORTED COMMAND, first failing LBA, run's last LBA.
`ifndef RBAD_CFG_SVH
`define RBAD_CFG_SVH

// Page layout
`define RBAD_PAGE_CODE      8'h42
`define RBAD_BYTE_CODE      6'h00
`define RBAD_BYTE_PLEN_HI   6'h02
`define RBAD_BYTE_PLEN_LO   6'h03
`define RBAD_BYTE_ENABLE    6'h04
`define RBAD_BYTE_ELEN      6'h07
`define RBAD_BYTE_FIELDS    6'h08
`define RBAD_BIT_ENABLE     0

// Sense codes
`define RBAD_SK_GOOD        4'h0
`define RBAD_SK_ILLEGAL     4'h5
`define RBAD_SK_ABORTED     4'hB
`define RBAD_ASC_NONE       8'h00
`define RBAD_ASC_INV_PARAM  8'h26
`define RBAD_ASC_INV_CDB    8'h24
`define RBAD_ASCQ_ZERO      8'h00

// Register byte offsets
`define RBAD_REG_STATUS     5'h00
`define RBAD_REG_SUPPORT    5'h04
`define RBAD_REG_DISABLED   5'h08
`define RBAD_REG_IRQ_STAT   5'h0C
`define RBAD_REG_IRQ_MASK   5'h10
`define RBAD_REG_SENSE      5'h14

// Register fields
`define RBAD_STATUS_MODE    0
`define RBAD_IRQ_MODE_CHG   0
`define RBAD_IRQ_REJECT     1
`define RBAD_IRQ_PRED_READ  2
`define RBAD_IRQ_BITS       3

// Reset values
`define RBAD_IRQ_MASK_RST   3'h0

`endif

// ===== src/rbad_pkg.sv
// Types for the rebuild-assist diagnostic page block
package rbad_pkg;

	// Input page streaming state
	typedef enum logic [0:0] {
		RBAD_OUT_IDLE = 1'b0,
		RBAD_OUT_SEND = 1'b1
	} rbad_out_state_type;

endpackage

// ===== test/rbad_monitor.sv
// Concurrent checks on the page handler ports
`timescale 1ns/1ps
`default_nettype none
module rbad_monitor #(
	parameter int         ELEM_BYTES = 2,
	parameter logic [7:0] MRE_ASC    = 8'h11,
	parameter logic [7:0] MRE_ASCQ   = 8'h1D
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Page streams and completion
	input wire logic       diag_req,
	input wire logic [7:0] diag_page,
	input wire logic       diag_req_ready,
	input wire logic       pg_out_valid,
	input wire logic [7:0] pg_out_data,
	input wire logic       pg_out_last,
	input wire logic       pg_out_ready,
	input wire logic       pg_in_valid,
	input wire logic [7:0] pg_in_data,
	input wire logic       pg_in_last,
	input wire logic       pg_in_ready,
	input wire logic       cmd_done,
	input wire logic       cmd_check,
	input wire logic [3:0] sense_key,
	input wire logic [7:0] sense_asc,
	// Read report
	input wire logic       read_end,
	input wire logic       read_done,
	input wire logic       read_check,
	input wire logic [3:0] read_key,
	input wire logic [7:0] read_asc,
	input wire logic [7:0] read_ascq
);
	logic [5:0] oc;
	logic [5:0] ic;
	logic       ie;
	logic [7:0] il;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Byte positions of both streams; output page fields caught on the fly
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc <= 6'h00;
			ic <= 6'h00;
			ie <= 1'b0;
			il <= 8'h00;
		end else begin
			if (pg_out_valid && pg_out_ready) oc <= pg_out_last ? 6'h00 : oc + 6'h01;
			if (pg_in_valid && pg_in_ready) ic <= pg_in_last ? 6'h00 : ic + 6'h01;
			if (pg_in_valid && pg_in_ready && ic == 6'h04) ie <= pg_in_data[0];
			if (pg_in_valid && pg_in_ready && ic == 6'h07) il <= pg_in_data;
		end
	end

	page_open_a: assert property (
		diag_req && diag_req_ready && diag_page == 8'h42 |=> pg_out_valid && pg_out_data == 8'h42)
		else $error("page code byte missing");
	bad_code_a: assert property (
		diag_req && diag_req_ready && diag_page != 8'h42 |=> cmd_done && cmd_check
		&& sense_key == 4'h5 && sense_asc == 8'h24) else $error("wrong page code accepted");
	page_len_a: assert property (
		pg_out_valid && oc == 6'h03 |-> pg_out_data == 8'(4 + 2 * ELEM_BYTES))
		else $error("page length byte wrong");
	elem_len_a: assert property (
		pg_out_valid && oc == 6'h07 |-> pg_out_data == 8'(ELEM_BYTES))
		else $error("element length byte wrong");
	last_pos_a: assert property (
		pg_out_valid && pg_out_last |-> oc == 6'(7 + 2 * ELEM_BYTES))
		else $error("last byte flagged at wrong place");
	bad_len_a: assert property (
		pg_in_valid && pg_in_ready && pg_in_last && ie && il != 8'(ELEM_BYTES) |-> ##2
		cmd_done && cmd_check && sense_key == 4'h5 && sense_asc == 8'h26)
		else $error("wrong element length not refused");
	read_rep_a: assert property (
		read_end |=> read_done) else $error("read report late");
	read_code_a: assert property (
		read_done && read_check |-> read_key == 4'hB && read_asc == MRE_ASC
		&& read_ascq == MRE_ASCQ) else $error("read report codes wrong");
endmodule
`default_nettype wire

// ===== test/rbad_init.sv
// Initiator model: sends output pages, sinks input pages slowly
`timescale 1ns/1ps
`default_nettype none
module rbad_init (
	// Bench control
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [95:0] pg,
	// Page streams
	output logic             pg_in_valid,
	output logic [7:0]       pg_in_data,
	output logic             pg_in_last,
	input  wire logic        pg_in_ready,
	output logic             pg_out_ready
);
	logic [3:0] idx;

	// Holds each byte until taken; after the last byte is taken, data shows its inverse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pg_in_valid <= 1'b0;
			pg_in_data  <= 8'h00;
			pg_in_last  <= 1'b0;
			idx         <= 4'h0;
		end else if (go) begin
			pg_in_valid <= 1'b1;
			pg_in_data  <= pg[95-:8];
			pg_in_last  <= 1'b0;
			idx         <= 4'h1;
		end else if (pg_in_valid && pg_in_ready) begin
			pg_in_valid <= !pg_in_last;
			pg_in_data  <= pg_in_last ? ~pg_in_data : pg[95-8*idx-:8];
			pg_in_last  <= (idx == 4'hB);
			idx         <= idx + 4'h1;
		end
	end

	// Stalls every other cycle, as a busy initiator may
	always_ff @(posedge clk or posedge rst) begin
		if (rst) pg_out_ready <= 1'b0;
		else pg_out_ready <= !pg_out_ready;
	end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the rebuild-assist page block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, diag_req = 1'b0, go = 1'b0;
	logic acc_valid = 1'b0, acc_read = 1'b0, read_start = 1'b0, read_end = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0, acc_lba = 32'h0, lba, readdata, read_info, read_csi;
	logic [7:0] diag_page = 8'h00, pg_out_data, pg_in_data, sense_asc, sense_ascq;
	logic [7:0] read_asc, read_ascq;
	logic [3:0] acc_elem = 4'h0, sense_key, read_key;
	logic [95:0] pg = 96'h0;
	logic waitrequest, irq, diag_req_ready, pg_out_valid, pg_out_last, pg_out_ready;
	logic pg_in_valid, pg_in_last, pg_in_ready, cmd_done, cmd_check, acc_done;
	logic acc_predicted, read_done, read_check, mode = 1'b0;
	logic [15:0] sup = 16'hFFFF, dis = 16'h0, rnd;
	logic [2:0] ist = 3'h0, msk = 3'h0;
	int seed = 32'h2d17b52d, miscompares = 0, compares = 0, cyc = 0;

	rbad_top rbad_top_i (
		.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest, .irq,
		.diag_req, .diag_page, .diag_req_ready, .pg_out_valid, .pg_out_data, .pg_out_last,
		.pg_out_ready, .pg_in_valid, .pg_in_data, .pg_in_last, .pg_in_ready, .cmd_done,
		.cmd_check, .sense_key, .sense_asc, .sense_ascq, .acc_valid, .acc_read, .acc_lba,
		.acc_elem, .acc_done, .acc_predicted, .read_start, .read_end, .read_done,
		.read_check, .read_key, .read_asc, .read_ascq, .read_info, .read_csi);
	rbad_init rbad_init_i (.clk, .rst, .go, .pg, .pg_in_valid, .pg_in_data, .pg_in_last,
		.pg_in_ready, .pg_out_ready);

	initial forever #10 clk = ~clk;

	task report_and_stop;
		if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Avalon access held until waitrequest drops; a read compares with e
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] e);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= e;
		do @(posedge clk); while (waitrequest);
		if (!wr) chk("reg", readdata, e);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	// Results request; the expected page is built from the model state
	task getpg(input logic [7:0] c);
		logic [95:0] e;
		e = {16'h4200, 16'h0008, 7'h0, mode, 16'h0, 8'h02, sup, dis};
		diag_req <= 1'b1;
		diag_page <= c;
		@(posedge clk);
		diag_req <= 1'b0;
		for (int k = 0; k < 12 && c == 8'h42; k++) begin
			do @(posedge clk); while (!(pg_out_valid && pg_out_ready));
			chk("byte", pg_out_data, e[95-8*k-:8]);
		end
		if (c == 8'h42) chk("last", pg_out_last, 1'b1);
		do @(posedge clk); while (!cmd_done);
		chk("req", {cmd_check, sense_key, sense_asc}, c == 8'h42 ? 13'h0 : 13'h1524);
	endtask

	// Output page with junk mask bytes; model decides refusal
	task send(input logic en, input logic [7:0] n, input logic [15:0] d);
		sendpg({16'h4200, 16'h0008, 7'h0, en, 16'h0, n, 16'hA55A, d}, en, d,
			en && (n != 8'h02 || |(d & ~sup) || (sup != 0 && (d & sup) == sup) || |(dis & ~d)));
	endtask

	// Any output page; a refused page leaves mode and dis untouched and only sets the reject bit in ist
	task sendpg(input logic [95:0] p, input logic en, input logic [15:0] d, input logic bad);
		pg <= p;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (!cmd_done);
		chk("send", {cmd_check, sense_key, sense_asc}, bad ? 13'h1526 : 13'h0);
		ist = ist | (bad ? 3'h2 : {2'h0, mode != en});
		if (!bad) begin
			mode = en;
			dis = en ? d : 16'h0;
		end
		bus(1'b0, 5'h00, {31'h0, mode});
		bus(1'b0, 5'h08, {16'h0, dis});
		chk("irq", irq, |(ist & msk));
	endtask

	task look(input logic rd, input logic [31:0] a, input logic [3:0] el);
		acc_valid <= 1'b1;
		acc_read <= rd;
		acc_lba <= a;
		acc_elem <= el;
		@(posedge clk);
		acc_valid <= 1'b0;
		@(posedge clk);
		chk("lookup", {acc_done, acc_predicted}, {1'b1, mode & dis[el]});
	endtask

	// Cuts a hung run short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop;
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, 5'h04, 32'hFFFF);
		bus(1'b0, 5'h18, 32'h0);
		getpg(8'h42);
		getpg(8'h37);
		bus(1'b1, 5'h10, 32'h7);
		msk = 3'h7;
		send(1'b1, 8'h02, 16'h0001);
		sendpg({16'h4200, 16'h0009, 8'h01, 16'h0, 8'h02, 32'h0000_0001}, 1'b1, 16'h0001, 1'b1);
		sendpg({16'h4300, 16'h0008, 8'h00, 16'h0, 8'h02, 32'h0000_0000}, 1'b0, 16'h0000, 1'b1);
		send(1'b1, 8'h03, 16'h0001);
		bus(1'b0, 5'h14, 32'h52600);
		send(1'b1, 8'h02, 16'h0000);
		send(1'b1, 8'h02, 16'hFFFF);
		rnd = 16'($random(seed));
		send(1'b1, 8'h02, (rnd & 16'h7FF1) | 16'h0001);
		getpg(8'h42);
		for (int i = 0; i < 16; i++) look(1'b0, 32'h0, i[3:0]);
		lba = $random(seed);
		read_start <= 1'b1;
		@(posedge clk);
		read_start <= 1'b0;
		look(1'b1, lba, 4'h0);
		look(1'b1, lba + 1, 4'h0);
		look(1'b1, lba + 2, 4'h1);
		look(1'b1, lba + 5, 4'h0);
		read_end <= 1'b1;
		@(posedge clk);
		read_end <= 1'b0;
		@(posedge clk);
		chk("rd", {read_done, read_check, read_key, read_asc, read_ascq}, 22'h3B111D);
		chk("first", read_info, lba);
		chk("run end", read_csi, lba + 1);
		ist = ist | 3'h4;
		bus(1'b1, 5'h04, 32'h00FF);
		sup = 16'h00FF;
		send(1'b1, 8'h02, dis | 16'h0100);
		send(1'b0, 8'h05, 16'hFFFF);
		getpg(8'h42);
		bus(1'b1, 5'h10, 32'h0);
		chk("masked", irq, 1'b0);
		bus(1'b0, 5'h0C, {29'h0, ist});
		bus(1'b1, 5'h00, 32'h1);
		bus(1'b0, 5'h0C, 32'h0);
		bus(1'b0, 5'h00, 32'h0);
		report_and_stop;
	end
endmodule

bind rbad_top rbad_monitor #(.ELEM_BYTES(ELEM_BYTES), .MRE_ASC(MRE_ASC), .MRE_ASCQ(MRE_ASCQ))
	rbad_monitor_i (.clk, .rst, .diag_req, .diag_page, .diag_req_ready, .pg_out_valid,
	.pg_out_data, .pg_out_last, .pg_out_ready, .pg_in_valid, .pg_in_data, .pg_in_last,
	.pg_in_ready, .cmd_done, .cmd_check, .sense_key, .sense_asc, .read_end, .read_done,
	.read_check, .read_key, .read_asc, .read_ascq);
`default_nettype wire
